/* File: dv/afe_fault_source.sv */
`timescale 1ns/1ns
// analog front end: fault levels change on the clock, as if already synchronised
module afe_fault_source (
	// clock
	input wire logic aclk,
	// requested and presented fault levels
	input wire logic [11:0] want,
	output logic [11:0] fault_cond
);
	initial fault_cond = 12'h000;
	always @(posedge aclk) begin
		fault_cond <= want;
	end
endmodule // afe_fault_source

/* File: dv/afe_sensor_config_and_error_mask_chk.sv */
`timescale 1ns/1ns
module afe_cfg_chk (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus handshakes
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	// faults and decoded controls
	input wire logic [11:0] fault_cond,
	input wire logic sensor_wiring_select_ff,
	input wire logic external_reference_resistor_select_ff,
	input wire logic [10:0] compensation_current_ua_ff,
	input wire logic [10:0] excitation_current_ua_ff,
	input wire logic [3:0] channel_gain_code_ff,
	input wire logic [14:0] channel_gain_milli_ff,
	input wire logic error_pin_ff
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	property p_wr_resp;
		s_wr_taken |=> !awready ##1 bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
	property p_rd_resp;
		arvalid && arready |=> rvalid && !arready;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read data missing");
	property p_ready_back;
		bvalid && bready |=> awready && wready;
	endproperty
	a_ready_back: assert property (p_ready_back) else $error("write channel not reopened");
	// wiring and resistor selects move only right after a write completes
	property p_cfg_on_write;
		$changed({sensor_wiring_select_ff, external_reference_resistor_select_ff}) |-> $past(bvalid);
	endproperty
	a_cfg_on_write: assert property (p_cfg_on_write) else $error("control moved without write");
	property p_comp_codes;
		compensation_current_ua_ff inside {11'h000, 11'h064, 11'h190, 11'h1f4, 11'h258, 11'h384, 11'h3e8};
	endproperty
	a_comp_codes: assert property (p_comp_codes) else $error("bad compensation current");
	property p_exc_codes;
		excitation_current_ua_ff inside {11'h000, 11'h064, 11'h190, 11'h1f4, 11'h258, 11'h384, 11'h3e8};
	endproperty
	a_exc_codes: assert property (p_exc_codes) else $error("bad excitation current");
	property p_gain;
		(channel_gain_code_ff != 4'h0 || channel_gain_milli_ff == 15'h00c8) &&
			(channel_gain_code_ff != 4'hf || channel_gain_milli_ff == 15'h5dc0);
	endproperty
	a_gain: assert property (p_gain) else $error("bad gain value");
	property p_pin_quiet;
		!$past(|(fault_cond & 12'hfc6)) |-> !error_pin_ff;
	endproperty
	a_pin_quiet: assert property (p_pin_quiet) else $error("error pin without fault");
endmodule // afe_cfg_chk

/* File: dv/tb_afe_sensor_config_and_error_mask.sv */
`timescale 1ns/1ns
module tb_afe_sensor_config_and_error_mask;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd;
	logic [11:0] want = 0, fault_cond;
	logic awready, wready, bvalid, arready, rvalid, error_pin_ff, irq_ff;
	logic sensor_wiring_select_ff, external_reference_resistor_select_ff;
	logic [1:0] bresp, rresp, rsp;
	logic [10:0] compensation_current_ua_ff, excitation_current_ua_ff;
	logic [3:0] channel_gain_code_ff, g;
	logic [14:0] channel_gain_milli_ff;
	logic [15:0] cfg;
	int checks = 0, fail_count = 0, p;
	logic [10:0] ua [8] = '{11'h000, 11'h064, 11'h190, 11'h1f4, 11'h1f4, 11'h258, 11'h384, 11'h3e8};
	logic [14:0] gm [16] = '{15'h00c8, 15'h00fa, 15'h012c, 15'h0177, 15'h01f4, 15'h02ee, 15'h03e8, 15'h05dc,
		15'h07d0, 15'h0bb8, 15'h0fa0, 15'h1770, 15'h1f40, 15'h2ee0, 15'h3e80, 15'h5dc0};
	int fpos [8] = '{11, 10, 9, 8, 7, 6, 2, 1};
	afe_fault_source afe_fault_source_inst (.aclk, .want, .fault_cond);
	afe_sensor_config_and_error_mask afe_sensor_config_and_error_mask_inst (.aclk, .aresetn, .awaddr,
		.awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .fault_cond,
		.sensor_wiring_select_ff, .compensation_current_ua_ff, .excitation_current_ua_ff,
		.external_reference_resistor_select_ff, .channel_gain_code_ff, .channel_gain_milli_ff, .error_pin_ff, .irq_ff);
	initial begin
		forever #10 aclk = ~aclk;
	end
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// each access starts one edge late so a strobe is never driven twice in one step
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// valid and ready are read here before this edge's updates land
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge aclk); while (!bvalid);
		rsp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rdt(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rdt(a);
		chk({14'h0, rsp, rd}, {16'h0000, exp});
	endtask
	task automatic settle;
		repeat (4) @(posedge aclk);
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		conclude();
	end
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(8'h14, 32'h0);
		rchk(8'h18, 32'h0);
		for (int i = 0; i < 16; i++) begin
			g = i[3:0];
			cfg = {g[0], g[2:0], g[3:1], g[1], g, 4'hf};
			wr(8'h14, cfg);
			rchk(8'h14, {16'h0000, cfg & 16'hfff0});
			chk({5'h0, sensor_wiring_select_ff, external_reference_resistor_select_ff, compensation_current_ua_ff,
				excitation_current_ua_ff, channel_gain_code_ff, channel_gain_milli_ff},
				{5'h0, g[0], g[1], ua[g[2:0]], ua[g[3:1]], g, gm[g]});
		end
		// unmapped and unaligned places answer with an error and zero data
		rdt(8'h08);
		chk({14'h0, rsp, rd}, {16'h0002, 32'h0});
		rdt(8'h15);
		chk({14'h0, rsp, rd}, {16'h0002, 32'h0});
		wr(8'h0c, 16'hffff);
		chk({46'h0, rsp}, 48'h2);
		wr(8'h18, 16'hffff);
		rchk(8'h18, 32'h0fc6);
		for (int k = 0; k < 8; k++) begin
			p = fpos[k];
			wr(8'h18, ~(16'h0001 << p));
			want <= 12'h001 << p;
			settle();
			chk({47'h0, error_pin_ff}, 48'h1);
			rchk(8'h00, 32'h1);
			wr(8'h18, 16'h0001 << p);
			settle();
			chk({47'h0, error_pin_ff}, 48'h0);
			rchk(8'h00, 32'h0);
			want <= 12'h000;
		end
		wr(8'h18, 16'h0000);
		want <= 12'h039;
		settle();
		chk({47'h0, error_pin_ff}, 48'h0);
		rchk(8'h00, 32'h0);
		want <= 12'h000;
		settle();
		rchk(8'h1c, 32'h0fc7);
		rchk(8'h1c, 32'h0);
		rchk(8'h40, 32'h0fc7);
		chk({47'h0, irq_ff}, 48'h0);
		wr(8'h44, 16'h0002);
		settle();
		chk({47'h0, irq_ff}, 48'h1);
		wr(8'h40, 16'hffff);
		settle();
		chk({47'h0, irq_ff}, 48'h0);
		rchk(8'h40, 32'h0);
		conclude();
	end
endmodule // tb_afe_sensor_config_and_error_mask
bind afe_sensor_config_and_error_mask afe_cfg_chk afe_cfg_chk_inst (.aclk, .aresetn, .awvalid, .awready, .wvalid,
	.wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .fault_cond, .sensor_wiring_select_ff,
	.external_reference_resistor_select_ff, .compensation_current_ua_ff, .excitation_current_ua_ff,
	.channel_gain_code_ff, .channel_gain_milli_ff, .error_pin_ff);

/* File: src/afe_cfg_map.vh */
`ifndef AFE_CFG_MAP_VH
`define AFE_CFG_MAP_VH

// register indices; the bus byte address is four times the index
`define IDX_TOP_STATUS 6'h00
`define IDX_SENSOR_CFG 6'h05
`define IDX_FAULT_MASK 6'h06
`define IDX_LATCHED_FAULT 6'h07
`define IDX_IRQ_STATUS 6'h10
`define IDX_IRQ_MASK 6'h11

// reset values
`define RST_SENSOR_CFG 16'h0000
`define RST_FAULT_MASK 16'h0000
`define RST_IRQ_MASK 16'h0000

// writable bits; reserved bits read as zero
`define WMASK_SENSOR_CFG 16'hfff0
`define WMASK_FAULT_MASK 16'h0fc6

// sensor configuration field positions
`define POS_WIRING 15
`define POS_COMP_HI 14
`define POS_COMP_LO 12
`define POS_EXC_HI 11
`define POS_EXC_LO 9
`define POS_EXT_RES 8
`define POS_GAIN_HI 7
`define POS_GAIN_LO 4

// fault positions, shared by latched status and interrupt registers and, except combined bit 0, by the mask
`define POS_NEG_UV 11
`define POS_POS_UV 10
`define POS_NEG_OV 9
`define POS_POS_OV 8
`define POS_EXC_FLT 7
`define POS_COMP_FLT 6
`define POS_FLD_OC 2
`define POS_IN_OC 1
`define POS_COMBINED 0

// top status: combined error bit
`define POS_TOP_ERR 0

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: src/afe_sensor_config_and_error_mask.v */
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "afe_cfg_map.vh"

// Notes on behaviour
// - bit 15 selects four-wire or two/three-wire
// - both current codes decode to identical microamp values
// - bit 8 selects internal or external resistor
// - gain code bits 7:4 decode to gain
// - mask bit one drops fault from summary
// - error pin uses the same masking
// - mask bits 11..6, 2, 1 map faults
// - combined error is top status bit
// - faults latched until latched status read
module afe_sensor_config_and_error_mask #(
	parameter ADDR_W = 8
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address
	input wire [ADDR_W-1:0] awaddr,
	input wire [2:0] awprot,
	input wire awvalid,
	output reg awready,
	// axi4-lite write data
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output reg wready,
	// axi4-lite write response
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	// axi4-lite read address
	input wire [ADDR_W-1:0] araddr,
	input wire [2:0] arprot,
	input wire arvalid,
	output reg arready,
	// axi4-lite read data
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	// live fault conditions from the analog front end
	input wire [11:0] fault_cond,
	// decoded controls toward the analog front end
	output reg sensor_wiring_select_ff,
	output reg [10:0] compensation_current_ua_ff,
	output reg [10:0] excitation_current_ua_ff,
	output reg external_reference_resistor_select_ff,
	output reg [3:0] channel_gain_code_ff,
	output reg [14:0] channel_gain_milli_ff,
	// real-time error pin and interrupt
	output reg error_pin_ff,
	output reg irq_ff
);

	// fault positions that exist; reserved mask positions contribute nothing
	localparam [11:0] FAULT_VALID = 12'hfc6;

	reg [15:0] sensor_cfg_ff;
	reg [15:0] fault_mask_ff;
	reg [15:0] irq_status_ff;
	reg [15:0] irq_mask_ff;
	reg [11:0] fault_prev_ff;
	reg combined_prev_ff;
	reg aw_got_ff;
	reg w_got_ff;
	reg [ADDR_W-1:0] awaddr_ff;
	reg [31:0] wdata_ff;
	reg [3:0] wstrb_ff;

	wire [15:0] latched_fault;
	wire [11:0] fault_live;
	wire combined_now;
	wire [15:0] fault_event;
	wire do_write;
	wire ar_take;
	wire rd_latched;
	wire [15:0] wr_val;
	wire [15:0] wr_lanes;
	wire [15:0] irq_clear;

	// register index from a byte address; unaligned addresses hit nothing
	function [6:0] reg_index;
		input [ADDR_W-1:0] addr;
		begin
			if (addr[1:0] != 2'b00) begin
				reg_index = 7'h7f;
			end else begin
				reg_index = {1'b0, addr[7:2]};
			end
		end
	endfunction

	function mapped;
		input [ADDR_W-1:0] addr;
		reg [6:0] idx;
		begin
			idx = reg_index(addr);
			mapped = (idx == {1'b0, `IDX_TOP_STATUS}) || (idx == {1'b0, `IDX_SENSOR_CFG}) ||
				(idx == {1'b0, `IDX_FAULT_MASK}) || (idx == {1'b0, `IDX_LATCHED_FAULT}) ||
				(idx == {1'b0, `IDX_IRQ_STATUS}) || (idx == {1'b0, `IDX_IRQ_MASK});
		end
	endfunction

	// both current sources share one magnitude table
	function [10:0] current_ua;
		input [2:0] code;
		begin
			case (code)
				3'h0: current_ua = 11'd0;
				3'h1: current_ua = 11'd100;
				3'h2: current_ua = 11'd400;
				3'h3: current_ua = 11'd500;
				3'h4: current_ua = 11'd500;
				3'h5: current_ua = 11'd600;
				3'h6: current_ua = 11'd900;
				3'h7: current_ua = 11'd1000;
				default: current_ua = 11'd0;
			endcase
		end
	endfunction

	// gain in thousandths so fractional settings stay exact
	function [14:0] gain_milli;
		input [3:0] code;
		begin
			case (code)
				4'h0: gain_milli = 15'd200;
				4'h1: gain_milli = 15'd250;
				4'h2: gain_milli = 15'd300;
				4'h3: gain_milli = 15'd375;
				4'h4: gain_milli = 15'd500;
				4'h5: gain_milli = 15'd750;
				4'h6: gain_milli = 15'd1000;
				4'h7: gain_milli = 15'd1500;
				4'h8: gain_milli = 15'd2000;
				4'h9: gain_milli = 15'd3000;
				4'ha: gain_milli = 15'd4000;
				4'hb: gain_milli = 15'd6000;
				4'hc: gain_milli = 15'd8000;
				4'hd: gain_milli = 15'd12000;
				4'he: gain_milli = 15'd16000;
				4'hf: gain_milli = 15'd24000;
				default: gain_milli = 15'd200;
			endcase
		end
	endfunction

	// summary of live faults
	assign fault_live = fault_cond & FAULT_VALID & ~fault_mask_ff[11:0];
	assign combined_now = |fault_live;

	// latched detail status: every valid fault, masked or not, plus the summary
	assign ar_take = arvalid && arready;
	assign rd_latched = ar_take && (reg_index(araddr) == {1'b0, `IDX_LATCHED_FAULT});

	fault_latch #(
		.W(16)
	) fault_latch_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.set_in({4'h0, fault_cond[11:1] & FAULT_VALID[11:1], combined_now}),
		.clr(rd_latched),
		.hold_ff(latched_fault)
	);

	// interrupt events: a fault rising, and the summary rising
	assign fault_event = {4'h0, fault_cond[11:1] & ~fault_prev_ff[11:1] & FAULT_VALID[11:1],
		combined_now & ~combined_prev_ff};

	// write path
	assign do_write = aw_got_ff && w_got_ff && !bvalid;
	assign wr_lanes = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
	assign wr_val = wdata_ff[15:0];
	assign irq_clear = (do_write && reg_index(awaddr_ff) == {1'b0, `IDX_IRQ_STATUS}) ?
		(wr_val & wr_lanes) : 16'h0000;

	always @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awaddr_ff <= {ADDR_W{1'b0}};
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			sensor_cfg_ff <= `RST_SENSOR_CFG;
			fault_mask_ff <= `RST_FAULT_MASK;
			irq_mask_ff <= `RST_IRQ_MASK;
		end else begin
			// address and data are taken independently, in either order
			if (awvalid && awready) begin
				aw_got_ff <= 1'b1;
				awaddr_ff <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				w_got_ff <= 1'b1;
				wdata_ff <= wdata;
				wstrb_ff <= wstrb;
				wready <= 1'b0;
			end
			if (do_write) begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				bvalid <= 1'b1;
				bresp <= mapped(awaddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
				case (reg_index(awaddr_ff))
					{1'b0, `IDX_SENSOR_CFG}: begin
						sensor_cfg_ff <= (sensor_cfg_ff & ~(wr_lanes & `WMASK_SENSOR_CFG)) |
							(wr_val & wr_lanes & `WMASK_SENSOR_CFG);
					end
					{1'b0, `IDX_FAULT_MASK}: begin
						fault_mask_ff <= (fault_mask_ff & ~(wr_lanes & `WMASK_FAULT_MASK)) |
							(wr_val & wr_lanes & `WMASK_FAULT_MASK);
					end
					{1'b0, `IDX_IRQ_MASK}: begin
						irq_mask_ff <= (irq_mask_ff & ~wr_lanes) | (wr_val & wr_lanes);
					end
					default: begin
						irq_mask_ff <= irq_mask_ff;
					end
				endcase
			end
			// channels reopen only after the response is taken
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// read path; a read of latched status samples before its clear lands
	always @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `RESP_OKAY;
		end else begin
			if (ar_take) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rresp <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
				case (reg_index(araddr))
					{1'b0, `IDX_TOP_STATUS}: rdata <= {31'h0, combined_now} << `POS_TOP_ERR;
					{1'b0, `IDX_SENSOR_CFG}: rdata <= {16'h0000, sensor_cfg_ff};
					{1'b0, `IDX_FAULT_MASK}: rdata <= {16'h0000, fault_mask_ff};
					{1'b0, `IDX_LATCHED_FAULT}: rdata <= {16'h0000, latched_fault};
					{1'b0, `IDX_IRQ_STATUS}: rdata <= {16'h0000, irq_status_ff};
					{1'b0, `IDX_IRQ_MASK}: rdata <= {16'h0000, irq_mask_ff};
					default: rdata <= 32'h00000000;
				endcase
			end
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// interrupt status: write one to clear, a new event beats the clear
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_ff <= 16'h0000;
			fault_prev_ff <= 12'h000;
			combined_prev_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			irq_status_ff <= fault_event | (irq_status_ff & ~irq_clear);
			fault_prev_ff <= fault_cond;
			combined_prev_ff <= combined_now;
			irq_ff <= |(irq_status_ff & irq_mask_ff);
		end
	end

	// decoded controls are registered so the analog side sees clean levels
	always @(posedge aclk) begin
		if (!aresetn) begin
			sensor_wiring_select_ff <= 1'b0;
			compensation_current_ua_ff <= 11'd0;
			excitation_current_ua_ff <= 11'd0;
			external_reference_resistor_select_ff <= 1'b0;
			channel_gain_code_ff <= 4'h0;
			channel_gain_milli_ff <= 15'd200;
			error_pin_ff <= 1'b0;
		end else begin
			sensor_wiring_select_ff <= sensor_cfg_ff[`POS_WIRING];
			compensation_current_ua_ff <= current_ua(sensor_cfg_ff[`POS_COMP_HI:`POS_COMP_LO]);
			excitation_current_ua_ff <= current_ua(sensor_cfg_ff[`POS_EXC_HI:`POS_EXC_LO]);
			external_reference_resistor_select_ff <= sensor_cfg_ff[`POS_EXT_RES];
			channel_gain_code_ff <= sensor_cfg_ff[`POS_GAIN_HI:`POS_GAIN_LO];
			channel_gain_milli_ff <= gain_milli(sensor_cfg_ff[`POS_GAIN_HI:`POS_GAIN_LO]);
			error_pin_ff <= combined_now;
		end
	end

endmodule // afe_sensor_config_and_error_mask

/* File: src/fault_latch.v */
`timescale 1ns/1ns

// sticky capture: a set arriving in the clearing cycle survives the clear
module fault_latch #(
	parameter W = 16
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// set and clear
	input wire [W-1:0] set_in,
	input wire clr,
	// held value
	output reg [W-1:0] hold_ff
);

	always @(posedge aclk) begin
		if (!aresetn) begin
			hold_ff <= {W{1'b0}};
		end else begin
			hold_ff <= set_in | (hold_ff & {W{~clr}});
		end
	end

endmodule // fault_latch
